// file: bench/testbench.sv
// testbench for the telemetry record formatter
// assumes the sink model and the shared consts header
`timescale 1ns/1ps
`default_nettype none
`include "ttr_consts.svh"

module testbench
  import ttr_pkg::*;
;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tx_valid;
  logic        tx_ready;
  ttr_beat_t   tx_beat;
  logic        stall;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  img[640];
  int          mismatches;
  int          total_checks;
  int          cycles;
  logic [11:0] ra[9] = '{`TTR_R_PIPE, `TTR_R_FRAMES, `TTR_R_TEMP, `TTR_R_ROI_LO, `TTR_R_ROI_HI,
                         `TTR_R_ZOOM, `TTR_R_ZOOM_X, `TTR_R_ZOOM_Y, `TTR_R_SYNC};
  logic [31:0] rm[9] = '{32'h0002_22FF, 32'h0000_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
                         32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_0001};
  int          rb[9] = '{110, 114, 162, 170, 174, 184, 188, 192, 312};
  int          rn[9] = '{4, 2, 4, 4, 4, 4, 4, 4, 2};

  ttr_formatter uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_beat(tx_beat));
  ttr_sink sink (.clk(clk), .rst_n(rst_n), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_beat(tx_beat), .stall(stall));

  always #50 clk = !clk;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_of_test();
    if (mismatches == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // an idle cycle before setup keeps each strobe to one assignment per step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // big endian field into the expected byte image
  task automatic put(input int b, input int n, input logic [31:0] v);
    for (int i = 0; i < n; i++)
      img[b + i] = v[8 * (n - 1 - i) +: 8];
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset value", (i == 1) ? {16'h0000, `TTR_RST_FRAMES} : 32'h0, rd);
      chk("mapped err", 32'h0, 32'(err));
    end
    chk("valid at rest", 32'h0, 32'(tx_valid));
    chk("ready", 32'h1, 32'(pready));
    apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
    apb(1'b0, 12'h0FC, 32'h0);
    chk("unmapped read", 32'h0, rd);
    chk("unmapped err", 32'h1, 32'(err));
  endtask

  task automatic t_regs();
    logic [31:0] v;
    for (int i = 0; i < 9; i++)
    begin
      v = (i == 0) ? 32'hFFFF_FFFF : 32'hF0E1_D2C3 + 32'(i) * 32'h0123_4567;
      apb(1'b1, ra[i], v);
      apb(1'b0, ra[i], 32'h0);
      chk("readback", v & rm[i], rd);
      put(rb[i], rn[i], v & rm[i]);
    end
  endtask

  // second start while busy must not restart or add beats
  task automatic t_record(input logic w, input logic s);
    int n;
    int k;
    logic [15:0] e;
    n = w ? 265 : 530;
    stall <= s;
    apb(1'b1, `TTR_R_CTRL, {30'h0, w, 1'b0});
    apb(1'b1, `TTR_R_CTRL, {30'h0, w, 1'b1});
    apb(1'b0, `TTR_R_STATUS, 32'h0);
    chk("busy", 32'h1, 32'(rd[0]));
    apb(1'b1, `TTR_R_CTRL, {30'h0, !w, 1'b1});
    k = 0;
    while (sink.beats.size() < n && k < 2000)
    begin
      @(posedge clk);
      k++;
    end
    repeat (8) @(posedge clk);
    chk("beats", 32'(n), 32'(sink.beats.size()));
    for (int i = 0; i < sink.beats.size() && i < n; i++)
    begin
      e = w ? {img[110 + 2 * i], img[111 + 2 * i]} : {8'h00, img[110 + i]};
      chk("data", 32'(e), 32'(sink.beats[i].data));
      chk("first", 32'(i == 0), 32'(sink.beats[i].first));
      chk("last", 32'(i == n - 1), 32'(sink.beats[i].last));
    end
    apb(1'b0, `TTR_R_STATUS, 32'h0);
    chk("idle", 32'h0, 32'(rd[0]));
    sink.beats.delete();
  endtask

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    stall = 1'b0;
    mismatches = 0;
    total_checks = 0;
    cycles = 0;
    for (int i = 0; i < 640; i++)
      img[i] = 8'h00;
    put(178, 2, 32'h0000_5A5A);
    put(180, 2, 32'h0000_A55A);
    put(182, 2, 32'h0000_A5A5);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_record(1'b0, 1'b1);
    t_record(1'b1, 1'b0);
    end_of_test();
  end
endmodule // testbench
`default_nettype wire

// file: bench/ttr_sink.sv
// capture sink model for the record stream
// assumes one clock shared with the formatter
`timescale 1ns/1ps
`default_nettype none

module ttr_sink
  import ttr_pkg::*;
(
  // clock and reset
  input  wire logic      clk,
  input  wire logic      rst_n,
  // record stream
  input  wire logic      tx_valid,
  output logic           tx_ready,
  input  wire ttr_beat_t tx_beat,
  // pacing
  input  wire logic      stall
);
  ttr_beat_t beats[$];
  logic      ph_q;

  initial
  begin
    ph_q = 1'b0;
    tx_ready = 1'b0;
  end

  // stalling halves the accept rate, so beats must hold
  always @(posedge clk)
  begin
    if (rst_n && tx_valid && tx_ready)
      beats.push_back(tx_beat);
    ph_q <= !ph_q;
    tx_ready <= rst_n && (!stall || ph_q);
  end
endmodule // ttr_sink
`default_nettype wire

// file: hw/ttr_formatter.sv
// telemetry record formatter, bytes 110..639 of the frame record
// assumes an APB master on clk and a capture sink with valid/ready
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ttr_consts.svh"

module ttr_formatter
  import ttr_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // record stream
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output ttr_beat_t        tx_beat
);

  // ----------------------------------------
  // byte lookup
  // ----------------------------------------
  // multi-byte fields go out most significant byte first
  function automatic logic [7:0] rec_byte(
    input logic [9:0]  b,
    input ttr_fields_t f
  );
    logic [31:0] w;
    logic [9:0]  o;
    w = 32'h0000_0000;
    o = 10'h000;
    if (b >= `TTR_B_PIPE && b < `TTR_B_FRAMES)
    begin
      w = f.pipe & `TTR_PIPE_MASK;
      o = b - `TTR_B_PIPE;
    end
    else if (b >= `TTR_B_FRAMES && b < `TTR_B_FRAMES + 10'd2)
    begin
      w = {f.frames, 16'h0000};
      o = b - `TTR_B_FRAMES;
    end
    else if (b >= `TTR_B_TEMP && b < `TTR_B_TEMP + 10'd4)
    begin
      w = f.temp;
      o = b - `TTR_B_TEMP;
    end
    else if (b >= `TTR_B_ROI_LO && b < `TTR_B_ROI_HI)
    begin
      w = f.roi_lo;
      o = b - `TTR_B_ROI_LO;
    end
    else if (b >= `TTR_B_ROI_HI && b < `TTR_B_PAT)
    begin
      w = f.roi_hi;
      o = b - `TTR_B_ROI_HI;
    end
    else if (b >= `TTR_B_PAT && b < `TTR_B_PAT + 10'd4)
    begin
      w = {`TTR_PAT_0, `TTR_PAT_1};
      o = b - `TTR_B_PAT;
    end
    else if (b >= `TTR_B_PAT + 10'd4 && b < `TTR_B_ZOOM)
    begin
      w = {`TTR_PAT_2, 16'h0000};
      o = b - `TTR_B_PAT - 10'd4;
    end
    else if (b >= `TTR_B_ZOOM && b < `TTR_B_ZOOM_X)
    begin
      w = f.zoom;
      o = b - `TTR_B_ZOOM;
    end
    else if (b >= `TTR_B_ZOOM_X && b < `TTR_B_ZOOM_Y)
    begin
      w = f.zoom_x;
      o = b - `TTR_B_ZOOM_X;
    end
    else if (b >= `TTR_B_ZOOM_Y && b < `TTR_B_ZOOM_Y + 10'd4)
    begin
      w = f.zoom_y;
      o = b - `TTR_B_ZOOM_Y;
    end
    else if (b >= `TTR_B_SYNC && b < `TTR_B_SYNC + 10'd2)
    begin
      // word 156 wins over the conflicting byte figure
      w = {15'h0, f.sync_slave, 16'h0000};
      o = b - `TTR_B_SYNC;
    end
    // anything else is reserved and stays zero
    return w[8'(8'd31 - {o[1:0], 3'b000}) -: 8];
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  ttr_state_t  st_q;
  ttr_state_t  st_d;
  ttr_fields_t fld_q;
  logic        wide_q;
  logic        run_wide_q;
  logic [9:0]  pos_q;
  logic [9:0]  pos_d;
  logic        vld_q;
  ttr_beat_t   beat_q;
  logic [31:0] rdat_q;
  logic        err_q;
  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire logic setup = psel & ~penable;
  wire logic wr_en = psel & penable & pwrite;
  wire logic hit_ctrl   = (paddr == `TTR_R_CTRL);
  wire logic hit_status = (paddr == `TTR_R_STATUS);
  wire logic hit_pipe   = (paddr == `TTR_R_PIPE);
  wire logic hit_frames = (paddr == `TTR_R_FRAMES);
  wire logic hit_temp   = (paddr == `TTR_R_TEMP);
  wire logic hit_roi_lo = (paddr == `TTR_R_ROI_LO);
  wire logic hit_roi_hi = (paddr == `TTR_R_ROI_HI);
  wire logic hit_zoom   = (paddr == `TTR_R_ZOOM);
  wire logic hit_zoom_x = (paddr == `TTR_R_ZOOM_X);
  wire logic hit_zoom_y = (paddr == `TTR_R_ZOOM_Y);
  wire logic hit_sync   = (paddr == `TTR_R_SYNC);
  wire logic hit_any = hit_ctrl | hit_status | hit_pipe | hit_frames
                     | hit_temp | hit_roi_lo | hit_roi_hi | hit_zoom
                     | hit_zoom_x | hit_zoom_y | hit_sync;
  logic [31:0] rmux;
  always_comb
  begin
    rmux = 32'h0000_0000;
    if (hit_ctrl)
      rmux = {30'h0, wide_q, 1'b0};
    else if (hit_status)
      rmux = {21'h0, pos_q, (st_q == TTR_SEND)};
    else if (hit_pipe)
      rmux = fld_q.pipe & `TTR_PIPE_MASK;
    else if (hit_frames)
      rmux = {16'h0000, fld_q.frames};
    else if (hit_temp)
      rmux = fld_q.temp;
    else if (hit_roi_lo)
      rmux = fld_q.roi_lo;
    else if (hit_roi_hi)
      rmux = fld_q.roi_hi;
    else if (hit_zoom)
      rmux = fld_q.zoom;
    else if (hit_zoom_x)
      rmux = fld_q.zoom_x;
    else if (hit_zoom_y)
      rmux = fld_q.zoom_y;
    else if (hit_sync)
      rmux = {31'h0, fld_q.sync_slave};
  end
  // read data and error are caught in the setup cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rdat_q <= 32'h0000_0000;
      err_q  <= 1'b0;
    end
    else if (setup)
    begin
      rdat_q <= pwrite ? 32'h0000_0000 : rmux;
      err_q  <= ~hit_any;
    end
  end
  assign prdata  = rdat_q;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & err_q;

  // ----------------------------------------
  // field registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      fld_q        <= '0;
      fld_q.frames <= `TTR_RST_FRAMES;
      wide_q       <= 1'b0;
    end
    else if (wr_en)
    begin
      if (hit_ctrl)   wide_q             <= pwdata[`TTR_CTRL_WIDE];
      if (hit_pipe)   fld_q.pipe         <= pwdata;
      if (hit_frames) fld_q.frames       <= pwdata[15:0];
      if (hit_temp)   fld_q.temp         <= pwdata;
      if (hit_roi_lo) fld_q.roi_lo       <= pwdata;
      if (hit_roi_hi) fld_q.roi_hi       <= pwdata;
      if (hit_zoom)   fld_q.zoom         <= pwdata;
      if (hit_zoom_x) fld_q.zoom_x       <= pwdata;
      if (hit_zoom_y) fld_q.zoom_y       <= pwdata;
      if (hit_sync)   fld_q.sync_slave   <= pwdata[0];
    end
  end

  // ----------------------------------------
  // record sequencer
  // ----------------------------------------
  // start while a record is running is ignored
  wire logic start = wr_en & hit_ctrl & pwdata[`TTR_CTRL_START]
                   & (st_q == TTR_IDLE);
  wire logic adv   = (st_q == TTR_SEND) & (~vld_q | tx_ready);
  wire logic [9:0] step = run_wide_q ? 10'd2 : 10'd1;
  wire logic [9:0] pos_nx = pos_q + step;
  wire logic fin = (pos_nx >= `TTR_B_END);
  always_comb
  begin
    st_d  = st_q;
    pos_d = pos_q;
    case (st_q)
      TTR_IDLE:
        if (start)
        begin
          st_d  = TTR_SEND;
          pos_d = `TTR_B_FIRST;
        end
      TTR_SEND:
        if (adv)
        begin
          pos_d = pos_nx;
          if (fin)
            st_d = TTR_IDLE;
        end
      default:
        st_d = TTR_IDLE;
    endcase
  end
  // wide beat pairs byte 2k (high) with 2k+1 (low)
  wire logic [7:0] byte_hi = rec_byte(pos_q, fld_q);
  wire logic [7:0] byte_lo = rec_byte(pos_q + 10'd1, fld_q);
  wire logic [15:0] beat_dat = run_wide_q ? {byte_hi, byte_lo}
                                          : {8'h00, byte_hi};
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_q       <= TTR_IDLE;
      pos_q      <= 10'h000;
      run_wide_q <= 1'b0;
      vld_q      <= 1'b0;
      beat_q     <= '0;
    end
    else
    begin
      st_q  <= st_d;
      pos_q <= pos_d;
      if (start)
        run_wide_q <= wide_q;
      if (adv)
      begin
        vld_q       <= 1'b1;
        beat_q.data <= beat_dat;
        beat_q.first <= (pos_q == `TTR_B_FIRST);
        beat_q.last <= fin;
      end
      else if (tx_ready)
        vld_q <= 1'b0;
    end
  end
  assign tx_valid = vld_q;
  assign tx_beat  = beat_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // field values are taken as they stood when the beat was loaded
  sequence s_wide_at(logic [9:0] p);
    adv && run_wide_q && pos_q == p;
  endsequence
  sequence s_narrow_at(logic [9:0] p);
    adv && !run_wide_q && pos_q == p;
  endsequence
  a_pipe_low: assert property (s_wide_at(`TTR_B_PIPE + 10'd2) |=>
    tx_beat.data == ($past(fld_q.pipe[15:0]) & 16'h22FF))
    else $error("pipeline flag low word wrong");
  a_pipe_high: assert property (s_wide_at(`TTR_B_PIPE) |=>
    tx_beat.data == {14'h0, $past(fld_q.pipe[17]), 1'b0})
    else $error("pipeline flag high word wrong");
  a_stage_byte: assert property (s_narrow_at(10'd113) |=>
    tx_beat.data == {8'h00, $past(fld_q.pipe[7:0])})
    else $error("stage flag byte wrong");
  a_frames_word: assert property (s_wide_at(`TTR_B_FRAMES) |=>
    tx_beat.data == $past(fld_q.frames))
    else $error("frame count word wrong");
  a_temp_low: assert property (s_wide_at(10'd164) |=>
    tx_beat.data == $past(fld_q.temp[15:0]))
    else $error("temperature low word wrong");
  a_roi_high: assert property (s_narrow_at(`TTR_B_ROI_HI) |=>
    tx_beat.data == {8'h00, $past(fld_q.roi_hi[31:24])})
    else $error("roi count byte wrong");
  a_pattern_run: assert property (s_wide_at(`TTR_B_PAT) |=>
    tx_beat.data == `TTR_PAT_0)
    else $error("check pattern word wrong");
  a_pattern_tail: assert property (s_wide_at(`TTR_B_PAT + 10'd4) |=>
    tx_beat.data == `TTR_PAT_2)
    else $error("check pattern last word wrong");
  a_pattern_byte: assert property (s_narrow_at(10'd180) |=>
    tx_beat.data == 16'h00A5)
    else $error("check pattern byte wrong");
  a_zoom_y: assert property (s_wide_at(10'd194) |=>
    tx_beat.data == $past(fld_q.zoom_y[15:0]))
    else $error("zoom centre word wrong");
  a_sync_word: assert property (s_wide_at(`TTR_B_SYNC) |=>
    tx_beat.data == {15'h0, $past(fld_q.sync_slave)})
    else $error("sync mode word wrong");
  a_reserved_zero: assert property (adv && (pos_q == 10'd116 ||
    pos_q == 10'd200 || pos_q == 10'd314) |=> tx_beat.data == 16'h0000)
    else $error("reserved position not zero");
  a_wide_end: assert property (s_wide_at(10'd638) |=>
    tx_beat.last && st_q == TTR_IDLE)
    else $error("wide record does not end at word 319");
  a_beat_hold: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_beat))
    else $error("beat changed while stalled");
endmodule // ttr_formatter
`default_nettype wire

// file: inc/ttr_consts.svh
// telemetry record formatter: offsets, field positions, reset values
// assumes inclusion by bare name from the testbench and the design file
`ifndef TTR_CONSTS_SVH
`define TTR_CONSTS_SVH

// ----------------------------------------
// record byte positions
// ----------------------------------------
`define TTR_B_FIRST   10'd110
`define TTR_B_PIPE    10'd110
`define TTR_B_FRAMES  10'd114
`define TTR_B_TEMP    10'd162
`define TTR_B_ROI_LO  10'd170
`define TTR_B_ROI_HI  10'd174
`define TTR_B_PAT     10'd178
`define TTR_B_ZOOM    10'd184
`define TTR_B_ZOOM_X  10'd188
`define TTR_B_ZOOM_Y  10'd192
`define TTR_B_SYNC    10'd312
`define TTR_B_END     10'd640

// ----------------------------------------
// field contents
// ----------------------------------------
`define TTR_PIPE_MASK 32'h0002_22FF
`define TTR_PAT_0     16'h5A5A
`define TTR_PAT_1     16'hA55A
`define TTR_PAT_2     16'hA5A5

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define TTR_R_CTRL    12'h000
`define TTR_R_STATUS  12'h004
`define TTR_R_PIPE    12'h008
`define TTR_R_FRAMES  12'h00C
`define TTR_R_TEMP    12'h010
`define TTR_R_ROI_LO  12'h014
`define TTR_R_ROI_HI  12'h018
`define TTR_R_ZOOM    12'h01C
`define TTR_R_ZOOM_X  12'h020
`define TTR_R_ZOOM_Y  12'h024
`define TTR_R_SYNC    12'h028

// ----------------------------------------
// field bits and reset values
// ----------------------------------------
`define TTR_CTRL_START 0
`define TTR_CTRL_WIDE  1
`define TTR_RST_FRAMES 16'h0008

`endif

// file: inc/ttr_pkg.sv
// types for the telemetry record formatter
// assumes ttr_consts.svh on the include path
`default_nettype none
package ttr_pkg;

  typedef enum logic [0:0] {
    TTR_IDLE = 1'b0,
    TTR_SEND = 1'b1
  } ttr_state_t;

  typedef struct packed {
    logic [31:0] pipe;
    logic [15:0] frames;
    logic [31:0] temp;
    logic [31:0] roi_lo;
    logic [31:0] roi_hi;
    logic [31:0] zoom;
    logic [31:0] zoom_x;
    logic [31:0] zoom_y;
    logic        sync_slave;
  } ttr_fields_t;

  typedef struct packed {
    logic [15:0] data;
    logic        first;
    logic        last;
  } ttr_beat_t;

endpackage
`default_nettype wire
